// file: vbr_pkg.sv
package vbr_pkg;
	// ---------------------------------------------------------------
	// Register map, byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] VBR_ADDR_CMD = 8'h00;
	localparam logic [7:0] VBR_ADDR_ARGS = 8'h04;
	localparam logic [7:0] VBR_ADDR_KEY_LO = 8'h08;
	localparam logic [7:0] VBR_ADDR_KEY_HI = 8'h0C;
	localparam logic [7:0] VBR_ADDR_RESULT = 8'h10;
	localparam logic [7:0] VBR_ADDR_BUF = 8'h40;
	localparam int VBR_ADDR_W = 8;
	localparam int VBR_BUF_BYTES = 64;
	localparam int VBR_BUF_WORDS = 16;
	localparam logic [8:0] VBR_BUF_LIMIT = 9'h040;
	localparam logic [8:0] VBR_RESULT_BYTES = 9'h005;
	localparam logic [2:0] VBR_LAST_BYTE = 3'h4;
	localparam logic [31:0] VBR_RST_WORD = 32'h0000_0000;
	localparam logic [1:0] VBR_RESP_OKAY = 2'h0;
	localparam logic [1:0] VBR_RESP_SLVERR = 2'h2;
	// ---------------------------------------------------------------
	// Command and selector fields
	// ---------------------------------------------------------------
	localparam logic [7:0] VBR_CMD_READ_VALUE = 8'h0A;
	localparam int VBR_SEL_KEY_B_BIT = 7;
	localparam int VBR_SEL_EXPL_BIT = 6;
	localparam logic [5:0] VBR_KEY_IDX_MAX = 6'h27;
	localparam int VBR_ARG_BLOCK_LSB = 0;
	localparam int VBR_ARG_OFFSET_LSB = 8;
	localparam int VBR_ARG_SEL_LSB = 16;
	// ---------------------------------------------------------------
	// Result codes
	// ---------------------------------------------------------------
	localparam logic [7:0] VBR_RES_OK = 8'h00;
	localparam logic [7:0] VBR_RES_BUSY = 8'h01;
	localparam logic [7:0] VBR_RES_BAD_CMD = 8'h02;
	localparam logic [7:0] VBR_RES_BAD_KEY = 8'h03;
	localparam logic [7:0] VBR_RES_AUTH = 8'h04;
	localparam logic [7:0] VBR_RES_READ = 8'h05;
	localparam logic [7:0] VBR_RES_NOT_VALUE = 8'h06;
	localparam logic [7:0] VBR_RES_RANGE = 8'h07;
	localparam int VBR_RES_BUSY_BIT = 31;
	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] block;
		logic [5:0] key_idx;
		logic key_b;
		logic key_explicit;
		logic [47:0] key;
	} vbr_tag_req_t;
	typedef struct packed {
		logic done;
		logic auth_ok;
		logic read_ok;
		logic [127:0] data;
	} vbr_tag_rsp_t;
	typedef enum logic [2:0] {VBR_IDLE, VBR_CHECK, VBR_WAIT, VBR_STORE} vbr_state_t;
endpackage : vbr_pkg

// file: vbr_value_read.sv
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Command code 0x0A starts value-block read.
// - Block index is absolute block ordinal.
// - Addressed block must be value-formatted.
// - Selector low six bits pick key 0-39.
// - Selector bit 7 set means Key B.
// - Selector bit 6 means explicit six-byte key.
// - Explicit key travels least significant byte first.
// - Key conflict resolved: bit 7 means B.
// - Behaves like raw block read otherwise.
// - Decode signed value and stored address.
// - On success write value then address.
// - Value LSB first, address unsigned byte.
module vbr_value_read (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [vbr_pkg::VBR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [vbr_pkg::VBR_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output vbr_pkg::vbr_tag_req_t tag_req,
	output logic tag_req_valid,
	input vbr_pkg::vbr_tag_rsp_t tag_rsp
);
	import vbr_pkg::*;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] vbr_merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] mask;
		mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old_w & ~mask) | (new_w & mask);
	endfunction : vbr_merge

	function automatic logic vbr_value_ok(input logic [127:0] d);
		return (d[63:32] == ~d[31:0]) && (d[95:64] == d[31:0]) && (d[111:104] == ~d[103:96])
			&& (d[119:112] == d[103:96]) && (d[127:120] == ~d[103:96]);
	endfunction : vbr_value_ok

	function automatic logic vbr_mapped(input logic [7:0] a);
		return (a[7:2] <= VBR_ADDR_RESULT[7:2]) || (a[7:6] == VBR_ADDR_BUF[7:6]);
	endfunction : vbr_mapped

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0] buf_mem [0:VBR_BUF_BYTES-1];
	logic aw_have_r, aw_have_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic w_have_r, w_have_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic awready_r, awready_nxt;
	logic wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic arready_r, arready_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] args_r, args_nxt;
	logic [31:0] key_lo_r, key_lo_nxt;
	logic [15:0] key_hi_r, key_hi_nxt;
	logic [7:0] result_r, result_nxt;
	vbr_state_t state_r, state_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [39:0] out_r, out_nxt;
	vbr_tag_req_t tag_req_r, tag_req_nxt;
	logic tag_valid_r, tag_valid_nxt;
	logic wr_fire, cmd_wr, busy, fsm_we;
	logic [3:0] host_buf_we;
	logic [5:0] fsm_addr;
	logic [7:0] fsm_data, sel, offset;

	assign busy = (state_r != VBR_IDLE);
	assign sel = args_r[VBR_ARG_SEL_LSB +: 8];
	assign offset = args_r[VBR_ARG_OFFSET_LSB +: 8];

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	always_comb
	begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt = w_have_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r && !s_axi_bready;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r && !s_axi_rready;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		args_nxt = args_r;
		key_lo_nxt = key_lo_r;
		key_hi_nxt = key_hi_r;
		cmd_wr = 1'b0;
		host_buf_we = 4'h0;
		wr_fire = aw_have_r && w_have_r && !bvalid_r;
		if (s_axi_awvalid && awready_r)
		begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r)
		begin
			w_have_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (wr_fire)
		begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = vbr_mapped(aw_addr_r) ? VBR_RESP_OKAY : VBR_RESP_SLVERR;
			cmd_wr = (aw_addr_r[7:2] == VBR_ADDR_CMD[7:2]) && w_strb_r[0];
			if (!busy && aw_addr_r[7:2] == VBR_ADDR_ARGS[7:2])
			begin
				args_nxt = vbr_merge(args_r, w_data_r, w_strb_r);
			end
			if (!busy && aw_addr_r[7:2] == VBR_ADDR_KEY_LO[7:2])
			begin
				key_lo_nxt = vbr_merge(key_lo_r, w_data_r, w_strb_r);
			end
			if (!busy && aw_addr_r[7:2] == VBR_ADDR_KEY_HI[7:2])
			begin
				key_hi_nxt = 16'(vbr_merge({16'h0000, key_hi_r}, w_data_r, w_strb_r));
			end
			if (!busy && aw_addr_r[7:6] == VBR_ADDR_BUF[7:6])
			begin
				host_buf_we = w_strb_r;
			end
		end
		if (s_axi_arvalid && arready_r)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = vbr_mapped(s_axi_araddr) ? VBR_RESP_OKAY : VBR_RESP_SLVERR;
			rdata_nxt = VBR_RST_WORD;
			case (s_axi_araddr[7:2])
				VBR_ADDR_CMD[7:2]: rdata_nxt = {24'h00_0000, VBR_CMD_READ_VALUE};
				VBR_ADDR_ARGS[7:2]: rdata_nxt = args_r;
				VBR_ADDR_KEY_LO[7:2]: rdata_nxt = key_lo_r;
				VBR_ADDR_KEY_HI[7:2]: rdata_nxt = {16'h0000, key_hi_r};
				VBR_ADDR_RESULT[7:2]: rdata_nxt = {24'h00_0000, result_r} | (32'(busy) << VBR_RES_BUSY_BIT);
				default:
				begin
					if (s_axi_araddr[7:6] == VBR_ADDR_BUF[7:6])
					begin
						rdata_nxt = {buf_mem[{s_axi_araddr[5:2], 2'h3}], buf_mem[{s_axi_araddr[5:2], 2'h2}],
							buf_mem[{s_axi_araddr[5:2], 2'h1}], buf_mem[{s_axi_araddr[5:2], 2'h0}]};
					end
				end
			endcase
		end
		awready_nxt = !aw_have_nxt && !bvalid_nxt;
		wready_nxt = !w_have_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_have_r <= 1'b0;
			w_data_r <= VBR_RST_WORD;
			w_strb_r <= 4'h0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= VBR_RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= VBR_RST_WORD;
			rresp_r <= VBR_RESP_OKAY;
			args_r <= VBR_RST_WORD;
			key_lo_r <= VBR_RST_WORD;
			key_hi_r <= 16'h0000;
		end
		else
		begin
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r <= w_have_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			args_r <= args_nxt;
			key_lo_r <= key_lo_nxt;
			key_hi_r <= key_hi_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Command sequencer
	// ---------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		result_nxt = result_r;
		cnt_nxt = cnt_r;
		out_nxt = out_r;
		tag_req_nxt = tag_req_r;
		tag_valid_nxt = tag_valid_r;
		fsm_we = 1'b0;
		fsm_addr = offset[5:0] + {3'h0, cnt_r};
		fsm_data = out_r[8*cnt_r +: 8];
		unique case (state_r)
			VBR_IDLE:
			begin
				if (cmd_wr && w_data_r[7:0] == VBR_CMD_READ_VALUE)
				begin
					state_nxt = VBR_CHECK;
					result_nxt = VBR_RES_BUSY;
				end
				else if (cmd_wr)
				begin
					result_nxt = VBR_RES_BAD_CMD;
				end
			end
			VBR_CHECK:
			begin
				state_nxt = VBR_IDLE;
				if (({1'b0, offset} + VBR_RESULT_BYTES) > VBR_BUF_LIMIT)
				begin
					result_nxt = VBR_RES_RANGE;
				end
				else if (!sel[VBR_SEL_EXPL_BIT] && (sel[5:0] > VBR_KEY_IDX_MAX))
				begin
					result_nxt = VBR_RES_BAD_KEY;
				end
				else
				begin
					tag_req_nxt.block = args_r[VBR_ARG_BLOCK_LSB +: 8];
					tag_req_nxt.key_idx = sel[5:0];
					tag_req_nxt.key_b = sel[VBR_SEL_KEY_B_BIT];
					tag_req_nxt.key_explicit = sel[VBR_SEL_EXPL_BIT];
					tag_req_nxt.key = {key_hi_r, key_lo_r};
					tag_valid_nxt = 1'b1;
					state_nxt = VBR_WAIT;
				end
			end
			VBR_WAIT:
			begin
				if (tag_rsp.done)
				begin
					tag_valid_nxt = 1'b0;
					state_nxt = VBR_IDLE;
					if (!tag_rsp.auth_ok)
					begin
						result_nxt = VBR_RES_AUTH;
					end
					else if (!tag_rsp.read_ok)
					begin
						result_nxt = VBR_RES_READ;
					end
					else if (!vbr_value_ok(tag_rsp.data))
					begin
						result_nxt = VBR_RES_NOT_VALUE;
					end
					else
					begin
						out_nxt = {tag_rsp.data[103:96], tag_rsp.data[31:0]};
						cnt_nxt = 3'h0;
						state_nxt = VBR_STORE;
					end
				end
			end
			VBR_STORE:
			begin
				fsm_we = 1'b1;
				cnt_nxt = cnt_r + 3'h1;
				if (cnt_r == VBR_LAST_BYTE)
				begin
					cnt_nxt = 3'h0;
					result_nxt = VBR_RES_OK;
					state_nxt = VBR_IDLE;
				end
			end
			default:
			begin
				state_nxt = VBR_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= VBR_IDLE;
			result_r <= VBR_RES_OK;
			cnt_r <= 3'h0;
			out_r <= 40'h00_0000_0000;
			tag_req_r <= '0;
			tag_valid_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			result_r <= result_nxt;
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
			tag_req_r <= tag_req_nxt;
			tag_valid_r <= tag_valid_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Data buffer
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (fsm_we)
		begin
			buf_mem[fsm_addr] <= fsm_data;
		end
		for (int k = 0; k < 4; k++)
		begin
			if (host_buf_we[k])
			begin
				buf_mem[{aw_addr_r[5:2], 2'(k)}] <= w_data_r[8*k +: 8];
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign tag_req = tag_req_r;
	assign tag_req_valid = tag_valid_r;
endmodule : vbr_value_read

// file: vbr_value_read_properties.sv
`timescale 1ns/1ps
// ----------
// Checker
// ----------
module vbr_value_read_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [vbr_pkg::VBR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire vbr_pkg::vbr_tag_req_t tag_req,
	input wire logic tag_req_valid,
	input wire vbr_pkg::vbr_tag_rsp_t tag_rsp
);
	import vbr_pkg::*;
	logic [31:0] args_r, klo_r;
	logic [15:0] khi_r;
	logic wr_w, cmd_w, go_w;
	assign wr_w = s_axi_wvalid && s_axi_wready && s_axi_awvalid;
	assign cmd_w = wr_w && s_axi_awaddr == VBR_ADDR_CMD;
	assign go_w = s_axi_wdata[7:0] == VBR_CMD_READ_VALUE && args_r[15:8] < 8'h3C
		&& (args_r[22] || args_r[21:16] <= VBR_KEY_IDX_MAX);
	always_ff @(posedge aclk)
	begin
		if (wr_w && s_axi_awaddr == VBR_ADDR_ARGS) args_r <= s_axi_wdata;
		if (wr_w && s_axi_awaddr == VBR_ADDR_KEY_LO) klo_r <= s_axi_wdata;
		if (wr_w && s_axi_awaddr == VBR_ADDR_KEY_HI) khi_r <= s_axi_wdata[15:0];
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_req_fields: assert property (
		tag_req_valid |-> tag_req.block == args_r[7:0] && tag_req.key_idx == args_r[21:16])
		else $error("request block or key index wrong");
	chk_key_kind: assert property (
		tag_req_valid |-> tag_req.key_b == args_r[23] && tag_req.key_explicit == args_r[22])
		else $error("request key kind wrong");
	chk_key_bytes: assert property (
		tag_req_valid && tag_req.key_explicit |-> tag_req.key == {khi_r, klo_r})
		else $error("request key bytes wrong");
	chk_req_hold: assert property (
		tag_req_valid && !tag_rsp.done |=> tag_req_valid && $stable(tag_req))
		else $error("request dropped early");
	chk_req_drop: assert property (
		tag_req_valid && tag_rsp.done |=> !tag_req_valid)
		else $error("request held after done");
	chk_cmd_start: assert property (
		cmd_w && go_w |-> ##[1:6] tag_req_valid)
		else $error("command did not start");
	chk_cmd_refuse: assert property (
		cmd_w && !go_w |-> ##1 !tag_req_valid [*6])
		else $error("refused command reached tag");
	chk_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	chk_wr_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
endmodule : vbr_value_read_properties

bind vbr_value_read vbr_value_read_properties u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .tag_req, .tag_req_valid, .tag_rsp);

// file: vbr_tag_model.sv
`timescale 1ns/1ps
// ----------
// Tag engine model
// ----------
module vbr_tag_model (
	input wire logic aclk,
	input wire vbr_pkg::vbr_tag_req_t tag_req,
	input wire logic tag_req_valid,
	input wire logic [3:0] lat,
	input wire logic auth_ok,
	input wire logic read_ok,
	output vbr_pkg::vbr_tag_rsp_t tag_rsp
);
	import vbr_pkg::*;
	logic [127:0] mem [0:255];
	logic [3:0] cnt;
	logic sent;
	initial
	begin
		cnt = 4'h0;
		sent = 1'b0;
		tag_rsp = '0;
	end
	always @(posedge aclk)
	begin
		tag_rsp.done <= 1'b0;
		tag_rsp.data <= ~tag_rsp.data;
		if (!tag_req_valid)
		begin
			cnt <= 4'h0;
			sent <= 1'b0;
		end
		else if (!sent && cnt == lat)
		begin
			tag_rsp <= {1'b1, auth_ok, read_ok, mem[tag_req.block]};
			sent <= 1'b1;
		end
		else
			cnt <= cnt + 4'h1;
	end
endmodule : vbr_tag_model

// file: vbr_value_read_tb.sv
`timescale 1ns/1ps
// ----------
// Bench
// ----------
module vbr_value_read_tb;
	import vbr_pkg::*;
	logic aclk, aresetn, auth_ok, read_ok;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, last_rd;
	logic [3:0] s_axi_wstrb, lat;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tag_req_valid;
	vbr_tag_req_t tag_req;
	vbr_tag_rsp_t tag_rsp;
	logic [31:0] sh [0:15];
	logic [34:0] exp_r [$];
	logic [1:0] exp_b [$];
	int mismatches, samples_checked;
	vbr_value_read u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .tag_req, .tag_req_valid, .tag_rsp);
	vbr_tag_model u_tag (.aclk, .tag_req, .tag_req_valid, .lat, .auth_ok, .read_ok, .tag_rsp);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic stop_test();
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: write response %h expected %h", $time, got, exp);
		end
	endtask : cmp_resp
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		exp_b.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input logic c);
		@(posedge aclk);
		exp_r.push_back({c, r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		last_rd = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic run(input logic [7:0] cm, blk, off, sel, input logic [2:0] ok, input logic [7:0] code);
		logic [31:0] v;
		logic [7:0] ad;
		logic [47:0] k;
		int i;
		v = rnd();
		ad = 8'(rnd());
		k = {16'(rnd()), rnd()};
		for (i = 0; i < 16; i++)
		begin
			sh[i] = rnd();
			wr(VBR_ADDR_BUF + 8'(4 * i), sh[i], VBR_RESP_OKAY);
		end
		u_tag.mem[blk] = {~ad, ad, ~ad, ad ^ {7'h00, ~ok[0]}, v, ~v, v};
		lat <= 4'(rnd());
		auth_ok <= ok[2];
		read_ok <= ok[1];
		wr(VBR_ADDR_ARGS, {8'h00, sel, off, blk}, VBR_RESP_OKAY);
		wr(VBR_ADDR_KEY_LO, k[31:0], VBR_RESP_OKAY);
		wr(VBR_ADDR_KEY_HI, {16'h0000, k[47:32]}, VBR_RESP_OKAY);
		wr(VBR_ADDR_CMD, {24'h00_0000, cm}, VBR_RESP_OKAY);
		i = 0;
		do
		begin
			rd(VBR_ADDR_RESULT, 32'h0000_0000, VBR_RESP_OKAY, 1'b0);
			i++;
		end while (last_rd[31] && i < 100);
		rd(VBR_ADDR_RESULT, {24'h00_0000, code}, VBR_RESP_OKAY, 1'b1);
		if (code == VBR_RES_OK)
			for (i = 0; i < 5; i++) sh[(off + i) / 4][8 * ((off + i) % 4) +: 8] = i < 4 ? v[8 * i +: 8] : ad;
		for (i = 0; i < 16; i++)
			rd(VBR_ADDR_BUF + 8'(4 * i), sh[i], VBR_RESP_OKAY, 1'b1);
	endtask : run
	always @(posedge aclk)
	begin
		if (s_axi_rvalid && s_axi_rready && exp_r[0][34])
			cmp({s_axi_rresp, s_axi_rdata}, exp_r[0][33:0]);
		if (s_axi_rvalid && s_axi_rready) void'(exp_r.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			cmp_resp(s_axi_bresp, exp_b.pop_front());
	end
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial
	begin
		repeat (30000) @(posedge aclk);
		mismatches++;
		stop_test();
	end
	initial
	begin
		seed = 32'h0000_0022;
		mismatches = 0;
		samples_checked = 0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, lat, auth_ok, read_ok} = '0;
		s_axi_wstrb = 4'hF;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		run(8'h0A, 8'h04, 8'h00, 8'h05, 3'b111, VBR_RES_OK);
		run(8'h0A, 8'h07, 8'h3B, 8'hC0, 3'b111, VBR_RES_OK);
		run(8'h0A, 8'h3E, 8'h11, 8'hA7, 3'b111, VBR_RES_OK);
		run(8'h0A, 8'h02, 8'h20, 8'h68, 3'b111, VBR_RES_OK);
		run(8'h0A, 8'h01, 8'h3C, 8'h05, 3'b111, VBR_RES_RANGE);
		run(8'h0A, 8'h01, 8'h11, 8'h28, 3'b111, VBR_RES_BAD_KEY);
		run(8'h0A, 8'h05, 8'h08, 8'h01, 3'b011, VBR_RES_AUTH);
		run(8'h0A, 8'h05, 8'h08, 8'h81, 3'b101, VBR_RES_READ);
		run(8'h0A, 8'h06, 8'h08, 8'h02, 3'b110, VBR_RES_NOT_VALUE);
		run(8'h0B, 8'h04, 8'h00, 8'h05, 3'b111, VBR_RES_BAD_CMD);
		wr(8'h20, 32'h0000_0000, VBR_RESP_SLVERR);
		rd(8'h20, 32'h0000_0000, VBR_RESP_SLVERR, 1'b1);
		stop_test();
	end
endmodule : vbr_value_read_tb
